//--- rtl/mds_cfg.svh
`ifndef MDS_CFG_SVH
`define MDS_CFG_SVH

// core clock period in ns (100 MHz)
`define MDS_CLK_NS 32'hA

// register word indices on the avalon slave (byte address = 4 * index)
`define MDS_REG_CMD 3'h0
`define MDS_REG_ADDR 3'h1
`define MDS_REG_WDATA 3'h2
`define MDS_REG_RDATA 3'h3
`define MDS_REG_SER 3'h4

// field positions
`define MDS_CMD_OP_LSB 0
`define MDS_ADDR_ROW_LSB 0
`define MDS_ADDR_COL_LSB 16
`define MDS_WDATA_MASK_LSB 4
`define MDS_SER_DIS_BIT 8
`define MDS_SER_SHIFT_BIT 9

// strobe phase length: least time, rounded up
`define MDS_PHASE_NS 32'h1E
`define MDS_PHASE_CYC (2'((`MDS_PHASE_NS + `MDS_CLK_NS - 32'h1) / `MDS_CLK_NS))

// serial clock half period: least time, rounded up
`define MDS_SCLK_HALF_NS 32'h3C
`define MDS_SCLK_HALF_CYC (4'((`MDS_SCLK_HALF_NS + `MDS_CLK_NS - 32'h1) / `MDS_CLK_NS))

// longest row strobe low time: 100 us, rounded down
`define MDS_RAS_MAX_US 32'h64
`define MDS_RAS_MAX_CYC ((`MDS_RAS_MAX_US * 32'h3E8) / `MDS_CLK_NS)

// refresh: 512 rows every 8 ms, interval rounded down
`define MDS_REFRESH_MS 32'h8
`define MDS_ROWS 32'h200
`define MDS_REF_INT_CYC (11'((`MDS_REFRESH_MS * 32'hF4240) / (`MDS_ROWS * `MDS_CLK_NS)))

// serial pointer top location
`define MDS_PTR_TOP 9'h1FF

// reset values
`define MDS_SER_DIS_RST 1'h1
`define MDS_DEV_OUT_RST 1'h1

`endif

//--- rtl/mds_pkg.sv
package mds_pkg;

  // operations that software can order
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_MWRITE = 3'h2,
    OP_REFRESH = 3'h3,
    OP_RDXFER = 3'h4,
    OP_WRXFER = 3'h5,
    OP_PSXFER = 3'h6
  } mds_op_t;

  // strobe sequencer states, gray from idle through precharge
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_ROW = 3'h3,
    ST_COL = 3'h2,
    ST_DATA = 3'h6,
    ST_PRE = 3'h7
  } mds_state_t;

  // true for the three transfer operations
  function automatic logic mds_is_xfer(input mds_op_t op);
    return (op == OP_RDXFER) || (op == OP_WRXFER) || (op == OP_PSXFER);
  endfunction

endpackage

//--- rtl/mds_refresh.sv
`timescale 1ns/10ps
`include "mds_cfg.svh"

// interval timer that asks for one refresh cycle per row slot
module mds_refresh (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic ack_in,
  output logic req_out
);

  logic [10:0] cnt_q; // cycles since the last slot
  logic req_q; // pending refresh

  // free running slot counter
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt_q <= 11'h0;
    end else if (ce_in) begin
      cnt_q <= (cnt_q == `MDS_REF_INT_CYC - 11'h1) ? 11'h0 : cnt_q + 11'h1; // see [RQ19]
    end
  end

  // a new slot wins over the ack so no slot is ever lost
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      req_q <= 1'h0;
    end else if (ce_in) begin
      if (cnt_q == `MDS_REF_INT_CYC - 11'h1) begin
        req_q <= 1'h1; // see [RQ19]
      end else if (ack_in) begin
        req_q <= 1'h0;
      end
    end
  end

  assign req_out = req_q;

endmodule // mds_refresh

//--- rtl/mds_serial.sv
`timescale 1ns/10ps
`include "mds_cfg.svh"

// serial port engine: makes the serial clock, shifts one word per pulse
module mds_serial (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [3:0] wdata_in,
  input wire logic host_drives_in,
  input wire logic load_tap_in,
  input wire logic [8:0] tap_in,
  input wire logic [3:0] sio_in,
  output logic sclk_out,
  output logic [3:0] sio_out,
  output logic [3:0] sio_oe_out,
  output logic [3:0] rdata_out,
  output logic [8:0] ptr_out,
  output logic busy_out
);

  logic [3:0] s1_q; // first sync stage
  logic [3:0] s2_q; // second sync stage
  logic [3:0] cnt_q; // half period counter
  logic hi_q; // in high half
  logic busy_q; // pulse in progress
  logic sclk_q; // serial clock pin
  logic [8:0] ptr_q; // mirror of the device pointer
  logic [3:0] rd_q; // last captured word
  logic [3:0] out_q; // word being driven
  logic oe_q; // drive enable
  logic half_end;
  logic rise;

  assign half_end = busy_q && (cnt_q == `MDS_SCLK_HALF_CYC - 4'h1);
  assign rise = half_end && !hi_q;

  // pin synchroniser
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end else if (ce_in) begin
      s1_q <= sio_in;
      s2_q <= s1_q;
    end
  end

  // low half first gives the written word setup time before the rise
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      busy_q <= 1'h0;
      hi_q <= 1'h0;
      cnt_q <= 4'h0;
      sclk_q <= 1'h0;
    end else if (ce_in) begin
      if (!busy_q) begin
        busy_q <= start_in; // see [RQ7]
        cnt_q <= 4'h0;
      end else if (half_end) begin
        cnt_q <= 4'h0;
        hi_q <= !hi_q;
        sclk_q <= !hi_q; // see [RQ1]
        busy_q <= !hi_q;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // pointer mirror: tap load, then one step per rising edge even when disabled
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ptr_q <= 9'h0;
    end else if (ce_in) begin
      if (load_tap_in) begin
        ptr_q <= tap_in; // see [RQ26]
      end else if (rise) begin
        ptr_q <= (ptr_q == `MDS_PTR_TOP) ? 9'h0 : ptr_q + 9'h1; // see [RQ2] see [RQ3] see [RQ8]
      end
    end
  end

  // data words; capture late in the high half, well after the access delay
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_q <= 4'h0;
      out_q <= 4'h0;
      oe_q <= 1'h0;
    end else if (ce_in) begin
      oe_q <= host_drives_in; // see [RQ9]
      if (start_in && !busy_q) begin
        out_q <= wdata_in;
      end
      if (half_end && hi_q) begin
        rd_q <= s2_q;
      end
    end
  end

  assign sclk_out = sclk_q;
  assign sio_out = out_q;
  assign sio_oe_out = {4{oe_q}};
  assign rdata_out = rd_q;
  assign ptr_out = ptr_q;
  assign busy_out = busy_q;

  property p_ptr_wrap;
    @(posedge core_clk_in) disable iff (rst_in)
    (ce_in && rise && !load_tap_in && ptr_q == `MDS_PTR_TOP) |=> (ptr_q == 9'h0);
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap to zero"); // see [RQ3]

  property p_ptr_inc;
    @(posedge core_clk_in) disable iff (rst_in)
    (ce_in && rise && !load_tap_in && ptr_q != `MDS_PTR_TOP) |=> (ptr_q == $past(ptr_q) + 9'h1);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not step by one"); // see [RQ2]

  property p_sclk_idle;
    @(posedge core_clk_in) disable iff (rst_in)
    (!busy_q && !start_in) |=> (!sclk_q)[*2];
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock moved while idle"); // see [RQ7]

endmodule // mds_serial

//--- rtl/mds_host_ctrl.sv
`timescale 1ns/10ps
`include "mds_cfg.svh"

// Operation
// [RQ1] device shifts one word per serial rise
// [RQ2] nine bit pointer steps each serial rise
// [RQ3] pointer wraps from 511 to 0
// [RQ4] serial read starts at read transfer tap
// [RQ5] serial write starts at transfer tap
// [RQ6] serial clock still during every transfer
// [RQ7] stop serial clock while port idles
// [RQ8] disabled port still advances pointer
// [RQ9] serial pin direction follows last transfer
// [RQ10] write transfer keeps input mode
// [RQ11] pseudo transfer only flips to input
// [RQ12] pins at row strobe fall select mode
// [RQ13] write transfer copies buffer to row
// [RQ14] serial traffic independent except transfers
// [RQ15] serial buffer is 512 by 4
// [RQ16] repeated read transfers keep refresh going
// [RQ17] row strobe low at most 100 us
// [RQ18] mask holds through fast page writes
// [RQ19] refresh all 512 rows per 8 ms
// [RQ20] any ordinary cycle refreshes its row
// [RQ21] column first refresh uses internal counter
// [RQ22] hidden refresh keeps read data out
// [RQ23] mask pins: zero blocks, one writes
// [RQ24] read transfer ends at enable rise
// [RQ25] row then column address on pins
// [RQ26] pointer takes tap when transfer ends
module mds_host_ctrl
  import mds_pkg::*;
#(
  parameter int unsigned RAS_MAX_CYC = `MDS_RAS_MAX_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [2:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic row_strobe_n_out,
  output logic col_strobe_n_out,
  output logic [8:0] addr_out,
  output logic transfer_or_output_enable_n_out,
  output logic masked_write_or_write_enable_n_out,
  output logic serial_port_enable_n_out,
  output logic serial_shift_clock_out,
  input wire logic [3:0] mask_and_data_pins_in,
  output logic [3:0] mask_and_data_pins_out,
  output logic [3:0] mask_and_data_pins_oe_out,
  input wire logic [3:0] serial_data_pins_in,
  output logic [3:0] serial_data_pins_out,
  output logic [3:0] serial_data_pins_oe_out
);

  // software visible state
  logic [8:0] row_q; // row for the next cycle
  logic [8:0] col_q; // column or tap for the next cycle
  logic [3:0] wdata_q; // random write data
  logic [3:0] mask_q; // write mask for masked writes
  logic [3:0] rd_q; // last random read word
  logic ser_dis_q; // serial port disabled (enable pin high)
  logic pend_q; // ordered operation waiting to run
  mds_op_t pend_op_q; // the waiting operation
  logic ser_dev_out_q; // device serial port in output mode

  // sequencer
  mds_state_t st_q; // strobe sequencer state
  mds_op_t op_q; // operation being run
  logic [1:0] ph_q; // cycle within a phase
  logic last_ph; // last cycle of a phase
  logic xfer_act; // a transfer owns the device
  logic xfer_end; // transfer just completed
  logic ref_req; // refresh slot pending
  logic ref_ack; // refresh cycle starting
  logic cmd_go; // ordered operation starting

  // pin registers and their next values
  logic ras_q, ras_d;
  logic cas_q, cas_d;
  logic [8:0] addr_q, addr_d;
  logic dt_q, dt_d;
  logic we_q, we_d;
  logic se_q, se_d;
  logic [3:0] dq_q, dq_d;
  logic dq_oe_q, dq_oe_d;

  // data pin synchroniser
  logic [3:0] dq_s1_q;
  logic [3:0] dq_s2_q;

  // bus side
  logic rd_ack_q; // read answered this cycle
  logic [31:0] rdata_q; // registered read data
  logic wr_blocked; // write must wait
  logic wr_take; // write accepted
  logic ser_shift_req; // write asks for a serial pulse

  // serial engine
  logic ser_busy;
  logic [3:0] ser_rd;
  logic [8:0] ser_ptr;

  // assertion helper: row strobe low time
  logic [13:0] ras_cnt_q;

  assign last_ph = (ph_q == `MDS_PHASE_CYC - 2'h1);
  assign xfer_act = (st_q != ST_IDLE) && mds_is_xfer(op_q);
  assign xfer_end = ce_in && (st_q == ST_PRE) && (ph_q == 2'h0) && mds_is_xfer(op_q);
  // refresh outranks ordered work; a transfer waits for the serial pulse to finish
  assign ref_ack = ce_in && (st_q == ST_IDLE) && ref_req;
  assign cmd_go = ce_in && (st_q == ST_IDLE) && !ref_req && pend_q
                  && !(mds_is_xfer(pend_op_q) && ser_busy); // see [RQ6]

  // sequencer state and phase counter
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE;
      ph_q <= 2'h0;
      op_q <= OP_READ;
    end else if (ce_in) begin
      if (st_q == ST_IDLE) begin
        ph_q <= 2'h0;
        if (ref_ack) begin
          op_q <= OP_REFRESH; // see [RQ19] see [RQ16]
          st_q <= ST_SETUP;
        end else if (cmd_go) begin
          op_q <= pend_op_q;
          st_q <= ST_SETUP;
        end
      end else if (!last_ph) begin
        ph_q <= ph_q + 2'h1;
      end else begin
        ph_q <= 2'h0;
        unique case (st_q)
          ST_SETUP: st_q <= ST_ROW;
          ST_ROW: st_q <= ST_COL;
          ST_COL: st_q <= ST_DATA;
          ST_DATA: st_q <= ST_PRE;
          ST_PRE: st_q <= ST_IDLE;
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // pin levels per state; mode pins stand from setup through the row strobe fall
  always_comb begin
    ras_d = 1'h1;
    cas_d = 1'h1;
    addr_d = row_q;
    dt_d = 1'h1;
    we_d = 1'h1;
    se_d = ser_dis_q;
    dq_d = 4'h0;
    dq_oe_d = 1'h0;
    if (st_q != ST_IDLE && st_q != ST_PRE) begin
      // row strobe falls in the row phase and stays low through the data phase
      ras_d = (st_q == ST_SETUP); // see [RQ17]
      unique case (op_q)
        OP_REFRESH: begin
          cas_d = 1'h0; // see [RQ21] see [RQ12]
        end
        OP_RDXFER: begin
          dt_d = 1'h0; // see [RQ12]
        end
        OP_WRXFER: begin
          dt_d = 1'h0;
          we_d = 1'h0;
          se_d = 1'h0; // see [RQ12] see [RQ13]
        end
        OP_PSXFER: begin
          dt_d = 1'h0;
          we_d = 1'h0;
          se_d = 1'h1; // see [RQ11] see [RQ12]
        end
        OP_MWRITE: begin
          we_d = (st_q != ST_SETUP && st_q != ST_ROW);
          dq_d = mask_q; // see [RQ23]
          dq_oe_d = 1'h1;
        end
        default: begin
        end
      endcase
      if (st_q == ST_COL || st_q == ST_DATA) begin
        // column phase: tap or column on the pins, column strobe low
        addr_d = col_q; // see [RQ25] see [RQ4] see [RQ5]
        // column strobe waits a cycle so address, data and write enable settle first
        if (st_q == ST_DATA || ph_q != 2'h0) begin
          cas_d = 1'h0;
        end
        if (op_q == OP_READ) begin
          dt_d = 1'h0;
        end
        if (op_q == OP_WRITE || op_q == OP_MWRITE) begin
          we_d = 1'h0; // early write, outputs stay off
          dq_d = wdata_q;
          dq_oe_d = 1'h1;
        end
      end
    end
  end

  // pin registers; the enable rise in precharge ends a transfer
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ras_q <= 1'h1;
      cas_q <= 1'h1;
      addr_q <= 9'h0;
      dt_q <= 1'h1;
      we_q <= 1'h1;
      se_q <= `MDS_SER_DIS_RST;
      dq_q <= 4'h0;
      dq_oe_q <= 1'h0;
    end else if (ce_in) begin
      ras_q <= ras_d;
      cas_q <= cas_d;
      addr_q <= addr_d;
      dt_q <= dt_d; // see [RQ24]
      we_q <= we_d;
      se_q <= se_d;
      dq_q <= dq_d;
      dq_oe_q <= dq_oe_d;
    end
  end

  // random read data come back through two flops before anyone looks
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dq_s1_q <= 4'h0;
      dq_s2_q <= 4'h0;
      rd_q <= 4'h0;
    end else if (ce_in) begin
      dq_s1_q <= mask_and_data_pins_in;
      dq_s2_q <= dq_s1_q;
      if (st_q == ST_DATA && last_ph && op_q == OP_READ) begin
        rd_q <= dq_s2_q;
      end
    end
  end

  // serial direction mirror; a write transfer in input mode stays input
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ser_dev_out_q <= `MDS_DEV_OUT_RST;
    end else if (xfer_end) begin
      ser_dev_out_q <= (op_q == OP_RDXFER); // see [RQ9] see [RQ10] see [RQ11]
    end
  end

  // bus write decode; a serial pulse never overlaps a transfer
  assign ser_shift_req = (avs_address_in == `MDS_REG_SER) && avs_writedata_in[`MDS_SER_SHIFT_BIT];
  always_comb begin
    wr_blocked = 1'h0;
    if (avs_address_in == `MDS_REG_CMD) begin
      wr_blocked = pend_q;
    end else if (ser_shift_req) begin
      wr_blocked = ser_busy || xfer_act || (pend_q && mds_is_xfer(pend_op_q)); // see [RQ6] see [RQ14]
    end
  end
  assign wr_take = ce_in && avs_write_in && !wr_blocked;
  assign avs_waitrequest_out = (avs_read_in && !rd_ack_q) || (avs_write_in && (wr_blocked || !ce_in));

  // software registers; the command clears as the sequencer takes it
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      row_q <= 9'h0;
      col_q <= 9'h0;
      wdata_q <= 4'h0;
      mask_q <= 4'h0;
      ser_dis_q <= `MDS_SER_DIS_RST;
      pend_q <= 1'h0;
      pend_op_q <= OP_READ;
    end else if (ce_in) begin
      if (cmd_go) begin
        pend_q <= 1'h0;
      end
      if (wr_take) begin
        unique case (avs_address_in)
          `MDS_REG_CMD: begin
            pend_q <= 1'h1;
            pend_op_q <= mds_op_t'(avs_writedata_in[`MDS_CMD_OP_LSB +: 3]);
          end
          `MDS_REG_ADDR: begin
            row_q <= avs_writedata_in[`MDS_ADDR_ROW_LSB +: 9];
            col_q <= avs_writedata_in[`MDS_ADDR_COL_LSB +: 9];
          end
          `MDS_REG_WDATA: begin
            wdata_q <= avs_writedata_in[3:0];
            mask_q <= avs_writedata_in[`MDS_WDATA_MASK_LSB +: 4];
          end
          `MDS_REG_SER: begin
            ser_dis_q <= avs_writedata_in[`MDS_SER_DIS_BIT]; // see [RQ8]
          end
          default: begin
          end
        endcase
      end
    end
  end

  // reads answer one cycle after they are seen; unmapped reads give zero
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_ack_q <= 1'h0;
      rdata_q <= 32'h0;
    end else if (ce_in) begin
      rd_ack_q <= avs_read_in && !rd_ack_q;
      if (avs_read_in && !rd_ack_q) begin
        unique case (avs_address_in)
          `MDS_REG_CMD: rdata_q <= {28'h0, ref_req, ser_busy, ser_dev_out_q, pend_q || (st_q != ST_IDLE)};
          `MDS_REG_ADDR: rdata_q <= {7'h0, col_q, 7'h0, row_q};
          `MDS_REG_WDATA: rdata_q <= {24'h0, mask_q, wdata_q};
          `MDS_REG_RDATA: rdata_q <= {28'h0, rd_q};
          `MDS_REG_SER: rdata_q <= {7'h0, ser_ptr, 7'h0, ser_dis_q, 4'h0, ser_rd};
          default: rdata_q <= 32'h0;
        endcase
      end
    end
  end

  // helper for the row strobe ceiling
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ras_cnt_q <= 14'h0;
    end else if (ce_in) begin
      ras_cnt_q <= ras_q ? 14'h0 : ras_cnt_q + 14'h1;
    end
  end

  mds_refresh mds_refresh_inst (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .ack_in(ref_ack),
    .req_out(ref_req)
  );

  mds_serial mds_serial_inst (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(wr_take && ser_shift_req),
    .wdata_in(avs_writedata_in[3:0]),
    .host_drives_in(!ser_dev_out_q),
    .load_tap_in(xfer_end),
    .tap_in(col_q),
    .sio_in(serial_data_pins_in),
    .sclk_out(serial_shift_clock_out),
    .sio_out(serial_data_pins_out),
    .sio_oe_out(serial_data_pins_oe_out),
    .rdata_out(ser_rd),
    .ptr_out(ser_ptr),
    .busy_out(ser_busy)
  );

  assign avs_readdata_out = rdata_q;
  assign row_strobe_n_out = ras_q;
  assign col_strobe_n_out = cas_q;
  assign addr_out = addr_q;
  assign transfer_or_output_enable_n_out = dt_q;
  assign masked_write_or_write_enable_n_out = we_q;
  assign serial_port_enable_n_out = se_q;
  assign mask_and_data_pins_out = dq_q;
  assign mask_and_data_pins_oe_out = {4{dq_oe_q}};

  property p_no_sclk_xfer;
    @(posedge core_clk_in) disable iff (rst_in)
    (xfer_act && $past(xfer_act)) |-> $stable(serial_shift_clock_out);
  endproperty
  a_no_sclk_xfer: assert property (p_no_sclk_xfer) else $error("serial clock moved in a transfer"); // see [RQ6]

  property p_ras_max;
    @(posedge core_clk_in) disable iff (rst_in)
    !ras_q |-> (ras_cnt_q < RAS_MAX_CYC);
  endproperty
  a_ras_max: assert property (p_ras_max) else $error("row strobe low too long"); // see [RQ17]

  property p_ref_issue;
    @(posedge core_clk_in) disable iff (rst_in)
    (ce_in && st_q == ST_IDLE && ref_req) |=> (st_q == ST_SETUP && op_q == OP_REFRESH);
  endproperty
  a_ref_issue: assert property (p_ref_issue) else $error("refresh slot not taken"); // see [RQ19]

  property p_rdxfer_decode;
    @(posedge core_clk_in) disable iff (rst_in)
    ($fell(row_strobe_n_out) && op_q == OP_RDXFER) |-> (!dt_q && we_q && cas_q);
  endproperty
  a_rdxfer_decode: assert property (p_rdxfer_decode) else $error("bad read transfer mode pins"); // see [RQ12]

  property p_mask_pins;
    @(posedge core_clk_in) disable iff (rst_in)
    ($fell(row_strobe_n_out) && op_q == OP_MWRITE) |-> (dq_oe_q && dq_q == mask_q && !we_q);
  endproperty
  a_mask_pins: assert property (p_mask_pins) else $error("mask not on pins at row fall"); // see [RQ23]

  property p_col_addr;
    @(posedge core_clk_in) disable iff (rst_in)
    ($fell(col_strobe_n_out) && op_q != OP_REFRESH) |-> (addr_q == col_q && !ras_q);
  endproperty
  a_col_addr: assert property (p_col_addr) else $error("column not on pins at column fall"); // see [RQ25]

  property p_dir_read;
    @(posedge core_clk_in) disable iff (rst_in)
    (xfer_end && op_q == OP_RDXFER && ce_in) |=> ser_dev_out_q ##1 (serial_data_pins_oe_out == 4'h0);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("still driving after read transfer"); // see [RQ9]

  property p_tap_load;
    @(posedge core_clk_in) disable iff (rst_in)
    xfer_end |=> (ser_ptr == $past(col_q));
  endproperty
  a_tap_load: assert property (p_tap_load) else $error("pointer mirror missed the tap"); // see [RQ26]

endmodule // mds_host_ctrl

//--- verification/mds_dev_model.sv
`timescale 1ns/10ps
// behavioural dual-port video memory on the far side of the strobes
module mds_dev_model (
  input wire logic row_n_in,
  input wire logic col_n_in,
  input wire logic [8:0] a_in,
  input wire logic xfer_n_in,
  input wire logic wen_n_in,
  input wire logic sen_n_in,
  input wire logic sclk_in,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  input wire logic [3:0] sio_in,
  output logic [3:0] sio_out
);
  logic [3:0] mem [0:262143]; // array, row then column
  logic [3:0] sbuf [0:511];
  logic [8:0] row, tap, ptr = 9'h0; // latched row, tap, pointer
  logic [3:0] msk, rd, so; // mask latch, read word, serial word
  logic [2:0] md = 3'h1; // 0 refresh, 1 random, 3 read, 4 write, 5 pseudo
  logic outm = 1'h1, xf = 1'h0, rdc = 1'h0; // direction, transfer open, read cycle
  int rcnt = 0, bad = 0; // refresh count, serial clock edges in transfers
  // the cycle is decoded once, at the row strobe fall
  always @(negedge row_n_in) begin
    row = a_in;
    msk = wen_n_in ? 4'hF : dq_in;
    if (!col_n_in)
      md = 0;
    else if (!xfer_n_in)
      md = wen_n_in ? 3'h3 : (sen_n_in ? 3'h5 : 3'h4);
    else
      md = 1;
    if (md == 0)
      rcnt++;
    xf = md > 2;
    rdc = 0;
  end
  // column fall: tap for transfers, data for random cycles
  always @(negedge col_n_in) if (!row_n_in) begin
    tap = a_in;
    rdc = md == 1 && wen_n_in;
    rd = mem[{row, a_in}];
    if (md == 1 && !wen_n_in)
      for (int i = 0; i < 4; i++) if (msk[i]) mem[{row, a_in}][i] = dq_in[i];
  end
  // released pins show the inverse, so a late sample cannot pass
  assign dq_out = (rdc && !col_n_in && !xfer_n_in) ? rd : ~rd;
  // a transfer ends at the enable rise and the pointer takes the tap
  always @(posedge xfer_n_in) if (xf) begin
    if (md == 3)
      for (int i = 0; i < 512; i++) sbuf[i] = mem[{row, 9'(i)}];
    if (md == 4)
      for (int i = 0; i < 512; i++) mem[{row, 9'(i)}] = sbuf[i];
    outm = md == 3;
    ptr = tap;
    xf = 0;
  end
  // each serial rise moves one word and steps the pointer
  always @(posedge sclk_in) begin
    if (xf)
      bad++;
    so = sbuf[ptr];
    if (!outm && !sen_n_in)
      sbuf[ptr] = sio_in;
    ptr = ptr + 9'h1;
  end
  assign sio_out = (outm && !sen_n_in) ? so : ~so;
endmodule // mds_dev_model

//--- verification/multiport_dram_mode_and_serial_port_tb.sv
`timescale 1ns/10ps
module multiport_dram_mode_and_serial_port_tb;
  import mds_pkg::*;
  logic clk = 0, rst = 1, rd_s = 0, wr_s = 0; // clock, reset, bus strobes
  logic [2:0] adr = 0; // bus word index
  logic [31:0] wd = 0, rdat, q; // bus data
  logic wq, row_n, col_n, xfer_n, wen_n, sen_n, sclk; // status and strobes
  logic [8:0] pa, r9, t9; // address pins, random row and tap
  logic [3:0] dqo, dqe, dqm, dqw, so, soe, sm, sw; // pin values and enables
  logic [3:0] v [0:2]; // words expected
  int fail_count = 0, check_count = 0, seed = 11, n;
  always #5 clk = ~clk;
  // each wire carries whichever party enables it
  assign dqw = (dqe & dqo) | (~dqe & dqm);
  assign sw = (soe & so) | (~soe & sm);
  mds_host_ctrl mds_host_ctrl_inst (.core_clk_in(clk), .rst_in(rst), .ce_in(1'h1), .avs_address_in(adr),
    .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wq), .row_strobe_n_out(row_n), .col_strobe_n_out(col_n), .addr_out(pa),
    .transfer_or_output_enable_n_out(xfer_n), .masked_write_or_write_enable_n_out(wen_n),
    .serial_port_enable_n_out(sen_n), .serial_shift_clock_out(sclk), .mask_and_data_pins_in(dqw),
    .mask_and_data_pins_out(dqo), .mask_and_data_pins_oe_out(dqe), .serial_data_pins_in(sw),
    .serial_data_pins_out(so), .serial_data_pins_oe_out(soe));
  mds_dev_model mds_dev_model_inst (.row_n_in(row_n), .col_n_in(col_n), .a_in(pa), .xfer_n_in(xfer_n),
    .wen_n_in(wen_n), .sen_n_in(sen_n), .sclk_in(sclk), .dq_in(dqw), .dq_out(dqm), .sio_in(sw), .sio_out(sm));
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // one bus transfer, held until waitrequest is low at an edge
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] o);
    int k;
    k = 0;
    adr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'h0 && k < 500);
    o = rdat;
    wr_s <= 0;
    rd_s <= 0;
    @(posedge clk);
    if (k >= 500) begin
      fail_count++;
      end_sim;
    end
  endtask
  // poll until no command and no serial pulse is busy
  task automatic idle;
    int k;
    k = 0;
    do begin
      bus(0, 3'h0, 0, q);
      k++;
    end while ((q[0] | q[2]) !== 1'h0 && k < 300);
    if (k >= 300) begin
      fail_count++;
      end_sim;
    end
  endtask
  task automatic cmd(input mds_op_t op, input logic [8:0] rw, input logic [8:0] cl, input logic [7:0] dat);
    bus(1, 3'h1, {7'h0, cl, 7'h0, rw}, q);
    bus(1, 3'h2, {24'h0, dat}, q);
    bus(1, 3'h0, {29'h0, op}, q);
    idle;
  endtask
  task automatic pulse(input logic [31:0] d);
    bus(1, 3'h4, d, q);
    idle;
    bus(0, 3'h4, 0, q);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk("serial clock idle", {31'h0, sclk}, 0);
    bus(0, 3'h4, 0, q);
    chk("serial reset", q, 32'h100);
    for (int i = 0; i < 4; i++) begin
      r9 = 9'($random(seed));
      t9 = 9'($random(seed));
      v[0] = 4'($random(seed));
      cmd(OP_WRITE, r9, t9, {4'h0, v[0]});
      cmd(OP_MWRITE, r9, t9, {4'h5, ~v[0]});
      cmd(OP_READ, r9, t9, 8'h0);
      bus(0, 3'h3, 0, q);
      chk("masked word", q, {28'h0, v[0] ^ 4'h5});
    end
    n = mds_dev_model_inst.rcnt;
    cmd(OP_REFRESH, 0, 0, 0);
    chk("refresh", {31'h0, mds_dev_model_inst.rcnt > n}, 1);
    for (int k = 0; k < 3; k++) begin
      v[k] = 4'($random(seed));
      cmd(OP_WRITE, r9, 9'h1FE + 9'(k), {4'h0, v[k]});
    end
    cmd(OP_RDXFER, r9, 9'h1FE, 0);
    chk("output mode", {31'h0, q[1]}, 1);
    bus(1, 3'h4, 0, q);
    for (int k = 0; k < 3; k++) begin
      pulse(32'h200);
      chk("serial out", {28'h0, q[3:0]}, {28'h0, v[k]});
    end
    chk("pointer wrap", {23'h0, q[24:16]}, 32'h1);
    pulse(32'h300);
    chk("pointer disabled", {23'h0, q[24:16]}, 32'h2);
    t9 = 9'($random(seed));
    cmd(OP_WRITE, r9 + 9'h1, t9, 8'h0);
    cmd(OP_PSXFER, r9 + 9'h1, t9, 0);
    chk("input mode", {31'h0, q[1]}, 0);
    bus(1, 3'h4, 0, q);
    for (int k = 0; k < 3; k++) begin
      v[k] = 4'($random(seed));
      pulse({22'h0, 10'h200 | v[k]});
    end
    cmd(OP_WRXFER, r9 + 9'h2, t9, 0);
    chk("input kept", {31'h0, q[1]}, 0);
    cmd(OP_PSXFER, r9 + 9'h1, t9, 0);
    cmd(OP_READ, r9 + 9'h1, t9, 8'h0);
    bus(0, 3'h3, 0, q);
    chk("pseudo moves none", q, 0);
    for (int k = 0; k < 3; k++) begin
      cmd(OP_READ, r9 + 9'h2, t9 + 9'(k), 8'h0);
      bus(0, 3'h3, 0, q);
      chk("written row", q, {28'h0, v[k]});
    end
    cmd(OP_RDXFER, r9 + 9'h2, t9, 0);
    chk("output again", {31'h0, q[1]}, 1);
    pulse(32'h200);
    chk("tap after input", {28'h0, q[3:0]}, {28'h0, v[0]});
    bus(1, 3'h7, 32'hFFFFFFFF, q);
    bus(0, 3'h7, 0, q);
    chk("unmapped", q, 0);
    chk("serial clock still", mds_dev_model_inst.bad, 0);
    end_sim;
  end
endmodule // multiport_dram_mode_and_serial_port_tb
